/* verilog/scrb_pkg.sv */
package scrb_pkg;

    // task-file offsets
    localparam logic [2:0] OFS_DATA     = 3'h0;
    localparam logic [2:0] OFS_ERR_FEAT = 3'h1;
    localparam logic [2:0] OFS_COUNT    = 3'h2;
    localparam logic [2:0] OFS_LBA_LO   = 3'h3;
    localparam logic [2:0] OFS_LBA_MID  = 3'h4;
    localparam logic [2:0] OFS_LBA_HI   = 3'h5;
    localparam logic [2:0] OFS_DRIVE    = 3'h6;
    localparam logic [2:0] OFS_STAT_CMD = 3'h7;

    // command, signature and subcommand codes
    localparam logic [7:0] CMD_SMART    = 8'hb0;
    localparam logic [7:0] SIG_MID      = 8'h4f;
    localparam logic [7:0] SIG_HI       = 8'hc2;
    localparam logic [7:0] SIG_DRIVE    = 8'ha0;
    localparam logic [7:0] SIG_MID_BAD  = 8'hf4;
    localparam logic [7:0] SIG_HI_BAD   = 8'h2c;
    localparam logic [7:0] SUB_RD_ATTR  = 8'hd0;
    localparam logic [7:0] SUB_RD_THR   = 8'hd1;
    localparam logic [7:0] SUB_AUTOSAVE = 8'hd2;
    localparam logic [7:0] SUB_ENABLE   = 8'hd8;
    localparam logic [7:0] SUB_DISABLE  = 8'hd9;
    localparam logic [7:0] SUB_STATUS   = 8'hda;
    localparam logic [7:0] CNT_ONE      = 8'h01;
    localparam logic [7:0] CNT_AS_ON    = 8'hf1;
    localparam logic [7:0] CNT_AS_OFF   = 8'h00;

    // status and error bits
    localparam int         ST_BSY_BIT   = 7;
    localparam int         ST_DRDY_BIT  = 6;
    localparam int         ST_DSC_BIT   = 4;
    localparam int         ST_DRQ_BIT   = 3;
    localparam int         ST_ERR_BIT   = 0;
    localparam logic [7:0] ERR_ABORT    = 8'h04;

    // reset values
    localparam logic [7:0]  TF_RESET    = 8'h00;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic        SMART_RESET = 1'b1;
    localparam logic        AUTOS_RESET = 1'b0;

    // one sector of 512 bytes is 256 words
    localparam logic [7:0] WORD_LAST    = 8'hff;
    localparam logic [8:0] TBL_BASE     = 9'h002;
    localparam logic [8:0] ENTRY_BYTES  = 9'h00c;
    localparam logic [4:0] ENTRY_NUM    = 5'h0b;
    localparam logic [7:0] TBL_REV      = 8'h10;
    localparam logic [7:0] ATTR_NORM    = 8'h64;

    // attribute table, entry 0 in the low byte
    localparam logic [87:0] ATTR_IDS  =
        88'hf1_e7_da_c2_c0_ad_aa_a8_0c_09_01;
    localparam logic [87:0] ATTR_FLAG =
        88'h12_13_0b_23_12_12_03_12_12_12_0b;
    localparam logic [87:0] ATTR_THR  =
        88'h00_00_32_00_00_00_0a_00_00_00_32;

    // addressable sectors per capacity, 32GB at index 0
    localparam logic [2:0]   CAP_LAST = 3'h6;
    localparam logic [223:0] CAP_512  = {
        32'd4000797360, 32'd2000409264, 32'd1000215216, 32'd500118192,
        32'd250069680, 32'd125045424, 32'd62533296};
    localparam logic [223:0] CAP_4K   = {
        32'd500099670, 32'd250051158, 32'd125026902, 32'd62514774,
        32'd31258710, 32'd15630678, 32'd7816662};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_XFER = 2'b11
    } scrb_state_type;

endpackage

/* verilog/scrb_attr_rom.sv */
`timescale 1ns/100ps
module scrb_attr_rom
(
    // word select
    input  wire logic [7:0]  word_idx_i,
    input  wire logic        thresh_sel_i,
    // sector word
    output logic [15:0]      word_o
);
    import scrb_pkg::*;

    // one byte of the attribute or threshold sector
    function automatic logic [7:0] byte_at(input logic [8:0] b, input logic thr);
        logic [8:0] p;
        logic [5:0] e;
        logic [3:0] o;
        logic [7:0] r;
        p = b - TBL_BASE;
        e = 6'(p / ENTRY_BYTES);
        o = 4'(p % ENTRY_BYTES);
        r = 8'h00;
        if (b < TBL_BASE)
        begin
            r = (b == 9'h000) ? TBL_REV : 8'h00;
        end
        else if (e < 6'(ENTRY_NUM))
        begin
            // raw counters read as zero; no counters live here
            unique case (o)
                4'h0: r = ATTR_IDS[8*e +: 8];
                4'h1: r = thr ? ATTR_THR[8*e +: 8] : ATTR_FLAG[8*e +: 8];
                4'h3: r = thr ? 8'h00 : ATTR_NORM;
                4'h4: r = thr ? 8'h00 : ATTR_NORM;
                default: r = 8'h00;
            endcase
        end
        return r;
    endfunction

    // low byte is the even byte of the sector
    always_comb
    begin
        word_o = {byte_at({word_idx_i, 1'b1}, thresh_sel_i),
                  byte_at({word_idx_i, 1'b0}, thresh_sel_i)};
    end

endmodule

/* verilog/scrb_smart_cmd.sv */
// Contract
// - 16-bit data word plus seven byte registers
// - 28-bit LBA across the task-file bytes
// - offset one: error read, feature write
// - offsets two to six read/write task file
// - offset seven: status read, command write
// - input is host-to-device, output device-to-host
// - feature 0xD0, count one: read attributes
// - feature 0xD1, count one: read thresholds
// - 0xD2 with count 0xF1 enables autosave
// - 0xD2 with count zero disables autosave
// - feature 0xD8 enables health monitoring
// - feature 0xD9 disables health monitoring
// - feature 0xDA reports overall health status
// - sectors are 512 bytes or 4 kilobytes
// - fixed addressable sector count per capacity
// - read attributes sends exactly one sector
`timescale 1ns/100ps
module scrb_smart_cmd
(
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                resetn_i,
    // host task-file port
    input  wire logic [2:0]          host_addr_i,
    input  wire logic                host_wr_i,
    input  wire logic                host_rd_i,
    input  wire logic [15:0]         host_wdata_i,
    output logic [15:0]              host_rdata_o,
    output logic                     host_rvalid_o,
    // straps and health input, asynchronous
    input  wire logic                sector_4k_i,
    input  wire logic [2:0]          capacity_sel_i,
    input  wire logic                health_fail_i,
    // device state
    output logic                     busy_o,
    output logic                     smart_enabled_o,
    output logic                     autosave_en_o,
    output logic [27:0]              cur_lba_o,
    output logic [31:0]              max_lba_o
);
    import scrb_pkg::*;

    scrb_state_type state;
    scrb_state_type next_state;

    logic [15:0] data_word;
    logic [7:0]  feature;
    logic [7:0]  count;
    logic [7:0]  lba_lo;
    logic [7:0]  lba_mid;
    logic [7:0]  lba_hi;
    logic [7:0]  drive;
    logic [7:0]  command;
    logic [7:0]  error;
    logic [7:0]  status;
    logic        smart_en;
    logic        autosave;
    logic        thr_sel;
    logic [7:0]  word_idx;
    logic [7:0]  csum;
    logic [15:0] rom_word;
    logic [15:0] xfer_word;
    logic [7:0]  last_hi;
    logic        wr_cmd;
    logic        wr_tf;
    logic        rd_data;

    logic [4:0]  strap_s1;
    logic [4:0]  strap_s2;

    logic        sig_ok;
    logic        dec_abort;
    logic        dec_xfer;
    logic        dec_thr;
    logic        dec_en_set;
    logic        dec_en_clr;
    logic        dec_as_set;
    logic        dec_as_clr;
    logic        dec_report;

    // host strobes, all on sys_clk; the host is logic in this domain
    assign wr_cmd  = host_wr_i && host_addr_i == OFS_STAT_CMD && state != ST_EXEC;
    assign wr_tf   = host_wr_i && state != ST_EXEC;
    assign rd_data = host_rd_i && host_addr_i == OFS_DATA && state == ST_XFER;

    // straps and the health flag cross in through two flip-flops
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            strap_s1 <= 5'h00;
            strap_s2 <= 5'h00;
        end
        else
        begin
            strap_s1 <= {health_fail_i, sector_4k_i, capacity_sel_i};
            strap_s2 <= strap_s1;
        end
    end

    // capacity report, reselected every cycle so a strap change follows
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            max_lba_o <= 32'h0000_0000;
        end
        else if (strap_s2[2:0] > CAP_LAST)
        begin
            max_lba_o <= 32'h0000_0000;
        end
        else if (strap_s2[3])
        begin
            max_lba_o <= CAP_4K[32*strap_s2[2:0] +: 32];
        end
        else
        begin
            max_lba_o <= CAP_512[32*strap_s2[2:0] +: 32];
        end
    end

    // signature bytes the host must have loaded before the command
    assign sig_ok = lba_mid == SIG_MID && lba_hi == SIG_HI && drive == SIG_DRIVE;

    // subcommand decode, acted on only while executing
    always_comb
    begin
        dec_abort  = 1'b0;
        dec_xfer   = 1'b0;
        dec_thr    = 1'b0;
        dec_en_set = 1'b0;
        dec_en_clr = 1'b0;
        dec_as_set = 1'b0;
        dec_as_clr = 1'b0;
        dec_report = 1'b0;
        if (command != CMD_SMART || !sig_ok)
        begin
            dec_abort = 1'b1;
        end
        else if (feature == SUB_ENABLE)
        begin
            dec_en_set = 1'b1;
        end
        else if (!smart_en)
        begin
            // a disabled feature set refuses all but enable
            dec_abort = 1'b1;
        end
        else
        begin
            unique case (feature)
                SUB_RD_ATTR:
                begin
                    dec_xfer  = count == CNT_ONE;
                    dec_abort = count != CNT_ONE;
                end
                SUB_RD_THR:
                begin
                    dec_xfer  = count == CNT_ONE;
                    dec_thr   = 1'b1;
                    dec_abort = count != CNT_ONE;
                end
                SUB_AUTOSAVE:
                begin
                    dec_as_set = count == CNT_AS_ON;
                    dec_as_clr = count == CNT_AS_OFF;
                    dec_abort  = count != CNT_AS_ON && count != CNT_AS_OFF;
                end
                SUB_DISABLE:
                begin
                    dec_en_clr = 1'b1;
                end
                SUB_STATUS:
                begin
                    dec_report = 1'b1;
                end
                default:
                begin
                    dec_abort = 1'b1;
                end
            endcase
        end
    end

    // command sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (wr_cmd)
                begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                next_state = dec_xfer ? ST_XFER : ST_IDLE;
            end
            ST_XFER:
            begin
                // a new command abandons the sector in flight
                if (wr_cmd)
                begin
                    next_state = ST_EXEC;
                end
                else if (rd_data && word_idx == WORD_LAST)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // task-file bytes; the health report overwrites the mid and high signature bytes, not drive, only while health_fail_i is set
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            data_word <= DATA_RESET;
            feature   <= TF_RESET;
            count     <= TF_RESET;
            lba_lo    <= TF_RESET;
            lba_mid   <= TF_RESET;
            lba_hi    <= TF_RESET;
            drive     <= TF_RESET;
            command   <= TF_RESET;
        end
        else if (state == ST_EXEC)
        begin
            if (dec_report && strap_s2[4])
            begin
                lba_mid <= SIG_MID_BAD;
                lba_hi  <= SIG_HI_BAD;
            end
        end
        else if (wr_tf)
        begin
            unique case (host_addr_i)
                OFS_DATA:     data_word <= host_wdata_i;
                OFS_ERR_FEAT: feature   <= host_wdata_i[7:0];
                OFS_COUNT:    count     <= host_wdata_i[7:0];
                OFS_LBA_LO:   lba_lo    <= host_wdata_i[7:0];
                OFS_LBA_MID:  lba_mid   <= host_wdata_i[7:0];
                OFS_LBA_HI:   lba_hi    <= host_wdata_i[7:0];
                OFS_DRIVE:    drive     <= host_wdata_i[7:0];
                OFS_STAT_CMD: command   <= host_wdata_i[7:0];
            endcase
        end
    end

    // error byte; a new command clears it, an abort sets it
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            error <= TF_RESET;
        end
        else if (state == ST_EXEC && dec_abort)
        begin
            error <= ERR_ABORT;
        end
        else if (wr_cmd)
        begin
            error <= TF_RESET;
        end
    end

    // feature-set enables survive until changed by a subcommand
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            smart_en <= SMART_RESET;
            autosave <= AUTOS_RESET;
        end
        else if (state == ST_EXEC)
        begin
            if (dec_en_set)
            begin
                smart_en <= 1'b1;
            end
            else if (dec_en_clr)
            begin
                smart_en <= 1'b0;
            end
            if (dec_as_set)
            begin
                autosave <= 1'b1;
            end
            else if (dec_as_clr)
            begin
                autosave <= 1'b0;
            end
        end
    end

    // sector stream position and running byte sum for the checksum
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            word_idx <= 8'h00;
            csum     <= 8'h00;
            thr_sel  <= 1'b0;
        end
        else if (state == ST_EXEC)
        begin
            word_idx <= 8'h00;
            csum     <= 8'h00;
            thr_sel  <= dec_thr;
        end
        else if (rd_data)
        begin
            word_idx <= word_idx + 8'h01;
            csum     <= csum + rom_word[7:0] + rom_word[15:8];
        end
    end

    scrb_attr_rom u_rom
    (
        .word_idx_i   (word_idx),
        .thresh_sel_i (thr_sel),
        .word_o       (rom_word)
    );

    // final byte makes the whole sector sum to zero
    assign last_hi   = 8'h00 - (csum + rom_word[7:0]);
    assign xfer_word = (word_idx == WORD_LAST) ? {last_hi, rom_word[7:0]} : rom_word;

    // status byte is built from live state, never stale
    always_comb
    begin
        status              = 8'h00;
        status[ST_BSY_BIT]  = state == ST_EXEC;
        status[ST_DRDY_BIT] = state != ST_EXEC;
        status[ST_DSC_BIT]  = state != ST_EXEC;
        status[ST_DRQ_BIT]  = state == ST_XFER;
        status[ST_ERR_BIT]  = state != ST_EXEC && error != TF_RESET;
    end

    // read data is registered: one cycle after the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            host_rdata_o  <= 16'h0000;
            host_rvalid_o <= 1'b0;
        end
        else
        begin
            host_rvalid_o <= host_rd_i;
            if (host_rd_i)
            begin
                unique case (host_addr_i)
                    OFS_DATA:     host_rdata_o <= rd_data ? xfer_word : data_word;
                    OFS_ERR_FEAT: host_rdata_o <= {8'h00, error};
                    OFS_COUNT:    host_rdata_o <= {8'h00, count};
                    OFS_LBA_LO:   host_rdata_o <= {8'h00, lba_lo};
                    OFS_LBA_MID:  host_rdata_o <= {8'h00, lba_mid};
                    OFS_LBA_HI:   host_rdata_o <= {8'h00, lba_hi};
                    OFS_DRIVE:    host_rdata_o <= {8'h00, drive};
                    OFS_STAT_CMD: host_rdata_o <= {8'h00, status};
                endcase
            end
        end
    end

    // outputs of device state
    assign busy_o          = state == ST_EXEC;
    assign smart_enabled_o = smart_en;
    assign autosave_en_o   = autosave;
    assign cur_lba_o       = {drive[3:0], lba_hi, lba_mid, lba_lo};

endmodule

/* verification/scrb_smart_cmd_checker.sv */
`timescale 1ns/100ps
module scrb_smart_cmd_checker
(
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    // host port
    input wire logic [2:0]  host_addr_i,
    input wire logic        host_wr_i,
    input wire logic        host_rd_i,
    input wire logic [15:0] host_wdata_i,
    input wire logic [15:0] host_rdata_o,
    input wire logic        host_rvalid_o,
    // straps and health
    input wire logic        sector_4k_i,
    input wire logic [2:0]  capacity_sel_i,
    input wire logic        health_fail_i,
    // device state
    input wire logic        busy_o,
    input wire logic        smart_enabled_o,
    input wire logic        autosave_en_o,
    input wire logic [27:0] cur_lba_o,
    input wire logic [31:0] max_lba_o
);
    import scrb_pkg::*;
    logic [7:0] feat_q;
    logic [7:0] drv_q;
    logic [7:0] cmd_q;
    logic [7:0] wlo;
    logic       sig_ok;
    default clocking dck @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // shadow bytes; writes while busy are dropped, as in the device
    always_ff @(posedge sys_clk_i)
    begin
        if (host_wr_i && !busy_o)
        begin
            case (host_addr_i)
                OFS_ERR_FEAT: feat_q <= host_wdata_i[7:0];
                OFS_DRIVE:    drv_q <= host_wdata_i[7:0];
                OFS_STAT_CMD: cmd_q <= host_wdata_i[7:0];
                default:      ;
            endcase
        end
    end
    // full signature present; feature byte decides
    assign sig_ok = drv_q == SIG_DRIVE && cur_lba_o[15:8] == SIG_MID && cur_lba_o[23:16] == SIG_HI;
    assign wlo = host_wdata_i[7:0];

    a_read_answer: assert property (host_rd_i |=> host_rvalid_o)
        else $error("read strobe got no answer");
    a_answer_cause: assert property (host_rvalid_o |-> $past(host_rd_i))
        else $error("answer without read strobe");
    a_byte_upper_zero: assert property (host_rvalid_o && $past(host_addr_i) != OFS_DATA
        |-> host_rdata_o[15:8] == 8'h00) else $error("byte register upper half not zero");
    a_cmd_starts: assert property (host_wr_i && !busy_o && host_addr_i == OFS_STAT_CMD
        |=> busy_o) else $error("command write did not start execution");
    a_busy_single: assert property (busy_o |=> !busy_o)
        else $error("busy longer than one cycle");
    a_lba_low_track: assert property (host_wr_i && !busy_o && host_addr_i == OFS_LBA_LO
        |=> cur_lba_o[7:0] == $past(wlo)) else $error("lba low byte not loaded");
    a_enable_on: assert property (busy_o && cmd_q == CMD_SMART && sig_ok
        && feat_q == SUB_ENABLE |=> smart_enabled_o) else $error("enable not taken");
    a_disable_off: assert property (busy_o && cmd_q == CMD_SMART && sig_ok
        && feat_q == SUB_DISABLE |=> !smart_enabled_o) else $error("disable not taken");
    a_smart_hold: assert property (!busy_o |=> $stable(smart_enabled_o))
        else $error("monitoring state moved without a command");
    a_autosave_hold: assert property (!busy_o |=> $stable(autosave_en_o))
        else $error("autosave state moved without a command");

    c_attr_read: cover property (busy_o && feat_q == SUB_RD_ATTR);
    c_disable: cover property ($fell(smart_enabled_o));
    c_autosave: cover property ($rose(autosave_en_o));
endmodule

bind scrb_smart_cmd scrb_smart_cmd_checker chk
(
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .sector_4k_i(sector_4k_i), .capacity_sel_i(capacity_sel_i),
    .health_fail_i(health_fail_i), .busy_o(busy_o), .smart_enabled_o(smart_enabled_o),
    .autosave_en_o(autosave_en_o), .cur_lba_o(cur_lba_o), .max_lba_o(max_lba_o)
);

/* verification/scrb_host_model.sv */
`timescale 1ns/100ps
module scrb_host_model
(
    // clock
    input  wire logic        sys_clk_i,
    // requests toward the device
    output logic [2:0]       host_addr_o,
    output logic             host_wr_o,
    output logic             host_rd_o,
    output logic [15:0]      host_wdata_o,
    // answers from the device
    input  wire logic [15:0] host_rdata_i,
    input  wire logic        host_rvalid_i
);
    // idle bus at time zero
    initial
    begin
        host_addr_o = 3'h0;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_wdata_o = 16'h0000;
    end

    // one-cycle write strobe; released lines are inverted
    task automatic wr(input logic [2:0] addr, input logic [15:0] data);
        @(negedge sys_clk_i);
        host_addr_o = addr;
        host_wdata_o = data;
        host_wr_o = 1'b1;
        @(negedge sys_clk_i);
        host_wr_o = 1'b0;
        host_addr_o = ~addr;
        host_wdata_o = ~data;
    endtask

    // answer taken as the strobe drops
    task automatic rd(input logic [2:0] addr, output logic [15:0] data, output logic valid);
        @(negedge sys_clk_i);
        host_addr_o = addr;
        host_rd_o = 1'b1;
        @(negedge sys_clk_i);
        host_rd_o = 1'b0;
        host_addr_o = ~addr;
        data = host_rdata_i;
        valid = host_rvalid_i;
    endtask
endmodule

/* verification/scrb_smart_cmd_tb.sv */
`timescale 1ns/100ps
module scrb_smart_cmd_tb;
    import scrb_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [31:0] CAP_S [7] = '{32'd62533296, 32'd125045424, 32'd250069680,
        32'd500118192, 32'd1000215216, 32'd2000409264, 32'd4000797360};
    localparam logic [31:0] CAP_L [7] = '{32'd7816662, 32'd15630678, 32'd31258710,
        32'd62514774, 32'd125026902, 32'd250051158, 32'd500099670};
    // feature, count, mid, command, status, {monitoring, autosave}
    localparam logic [47:0] DEC [11] = '{48'hd2f14fb05003, 48'hd2054fb05103,
        48'hd0024fb05103, 48'hd1004fb05103, 48'he0014fb05103, 48'hd801f4b05103,
        48'hd8014fec5103, 48'hd9004fb05001, 48'hd2004fb05101, 48'hd8004fb05003,
        48'hd2004fb05002};
    logic        sys_clk_i = 1'b0;
    logic        resetn_i;
    logic        sector_4k_i;
    logic [2:0]  capacity_sel_i;
    logic        health_fail_i;
    logic [2:0]  host_addr;
    logic        host_wr;
    logic        host_rd;
    logic [15:0] host_wdata;
    logic [15:0] host_rdata;
    logic        host_rvalid;
    logic        busy;
    logic        smart_en;
    logic        autosave;
    logic [27:0] cur_lba;
    logic [31:0] max_lba;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    scrb_smart_cmd dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_addr_i(host_addr),
        .host_wr_i(host_wr), .host_rd_i(host_rd), .host_wdata_i(host_wdata),
        .host_rdata_o(host_rdata), .host_rvalid_o(host_rvalid), .sector_4k_i(sector_4k_i),
        .capacity_sel_i(capacity_sel_i), .health_fail_i(health_fail_i), .busy_o(busy),
        .smart_enabled_o(smart_en), .autosave_en_o(autosave), .cur_lba_o(cur_lba),
        .max_lba_o(max_lba));
    scrb_host_model host (.sys_clk_i(sys_clk_i), .host_addr_o(host_addr), .host_wr_o(host_wr),
        .host_rd_o(host_rd), .host_wdata_o(host_wdata), .host_rdata_i(host_rdata),
        .host_rvalid_i(host_rvalid));

    task automatic print_verdict;
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic get(input logic [2:0] addr, output logic [15:0] d);
        logic v;
        host.rd(addr, d, v);
        chk_val("read answer", 32'h1, {31'h0, v});
    endtask

    task automatic rd_chk(input string what, input logic [2:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        get(addr, d);
        chk_val(what, {16'h0, exp}, {16'h0, d});
    endtask

    // signature bytes always go in before the command byte
    task automatic cmd(input logic [7:0] feat, input logic [7:0] cnt, input logic [7:0] mid,
                       input logic [7:0] code);
        host.wr(OFS_ERR_FEAT, {8'h00, feat});
        host.wr(OFS_COUNT, {8'h00, cnt});
        host.wr(OFS_LBA_MID, {8'h00, mid});
        host.wr(OFS_LBA_HI, {8'h00, SIG_HI});
        host.wr(OFS_DRIVE, {8'h00, SIG_DRIVE});
        host.wr(OFS_STAT_CMD, {8'h00, code});
        chk_val("busy", 32'h1, {31'h0, busy});
        @(negedge sys_clk_i);
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(8'h3c ^ (i * 37));
    endfunction

    task automatic t_reset;
        rd_chk("status", OFS_STAT_CMD, 16'h0050);
        rd_chk("error", OFS_ERR_FEAT, 16'h0000);
        chk_val("monitoring", 32'h1, {31'h0, smart_en});
        chk_val("autosave", 32'h0, {31'h0, autosave});
    endtask

    // feature write must not show in the error read
    task automatic t_regs;
        host.wr(OFS_DATA, 16'hc35a);
        rd_chk("data word", OFS_DATA, 16'hc35a);
        host.wr(OFS_ERR_FEAT, 16'h00d5);
        rd_chk("error", OFS_ERR_FEAT, 16'h0000);
        for (int i = 2; i < 7; i++)
            host.wr(3'(i), {8'h00, pat(i)});
        for (int i = 2; i < 7; i++)
            rd_chk("task file", 3'(i), {8'h00, pat(i)});
        chk_val("lba", 32'h0285a853, {4'h0, cur_lba});
    endtask

    task automatic t_decode;
        logic [47:0] e;
        for (int i = 0; i < 11; i++)
        begin
            e = DEC[i];
            cmd(e[47:40], e[39:32], e[31:24], e[23:16]);
            rd_chk("status", OFS_STAT_CMD, {8'h00, e[15:8]});
            rd_chk("error", OFS_ERR_FEAT, e[15:8] == 8'h51 ? 16'h0004 : 16'h0000);
            chk_val("monitoring", {31'h0, e[1]}, {31'h0, smart_en});
            chk_val("autosave", {31'h0, e[0]}, {31'h0, autosave});
        end
    endtask

    task automatic t_health;
        cmd(SUB_STATUS, 8'h00, SIG_MID, CMD_SMART);
        rd_chk("status", OFS_STAT_CMD, 16'h0050);
        chk_val("signature", 32'h0000c24f, {16'h0, cur_lba[23:8]});
        health_fail_i = 1'b1;
        cmd(SUB_STATUS, 8'h00, SIG_MID, CMD_SMART);
        chk_val("signature", 32'h00002cf4, {16'h0, cur_lba[23:8]});
        rd_chk("lba mid", OFS_LBA_MID, 16'h00f4);
        health_fail_i = 1'b0;
    endtask

    // last byte balances the sector sum to zero
    task automatic t_sector(input logic [7:0] feat, input logic [15:0] w1, input logic [15:0] w2);
        logic [15:0] d;
        logic [7:0]  sum;
        cmd(feat, CNT_ONE, SIG_MID, CMD_SMART);
        rd_chk("status", OFS_STAT_CMD, 16'h0058);
        sum = 8'h00;
        for (int i = 0; i < 256; i++)
        begin
            get(OFS_DATA, d);
            sum = sum + d[7:0] + d[15:8];
            if (i == 0)
                chk_val("word 0", 32'h0010, {16'h0, d});
            if (i == 1)
                chk_val("word 1", {16'h0, w1}, {16'h0, d});
            if (i == 2)
                chk_val("word 2", {16'h0, w2}, {16'h0, d});
            if (i == 255)
                chk_val("word 255 low", 32'h0, {24'h0, d[7:0]});
        end
        chk_val("checksum", 32'h0, {24'h0, sum});
        rd_chk("status", OFS_STAT_CMD, 16'h0050);
    endtask

    // strap 7 is unused and reports zero
    task automatic t_straps;
        logic [31:0] e;
        for (int i = 0; i < 16; i++)
        begin
            capacity_sel_i = 3'(i >> 1);
            sector_4k_i = i[0];
            repeat (4) @(negedge sys_clk_i);
            e = (i >> 1) == 7 ? 32'h0 : (i[0] ? CAP_L[i >> 1] : CAP_S[i >> 1]);
            chk_val("sector total", e, max_lba);
        end
    endtask

    // hang guard
    always @(posedge sys_clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == LIMIT)
        begin
            failures = failures + 1;
            print_verdict();
        end
    end

    initial
    begin
        resetn_i = 1'b0;
        sector_4k_i = 1'b0;
        capacity_sel_i = 3'h0;
        health_fail_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        t_reset();
        t_regs();
        t_decode();
        t_health();
        t_sector(SUB_RD_ATTR, 16'h0b01, 16'h6400);
        t_sector(SUB_RD_THR, 16'h3201, 16'h0000);
        t_straps();
        print_verdict();
    end
endmodule
